// [hdl/fijx_alu.sv]
// byte unit: complement, decrement or increment of a file operand, with zero detect
// assumes operand arrives from flip-flops or the file read port on the same clock
`timescale 1ns/100ps
`default_nettype none
`include "fijx_map.svh"

module fijx_alu
	import fijx_pkg::*;
(
	input  wire fijx_alu_type              op,
	input  wire logic [`FIJX_DATA_W-1:0]   operand,
	output logic      [`FIJX_DATA_W-1:0]   result,
	output logic                           zero
);

	// result selection, wraps modulo 256
	always_comb
	begin
		unique case (op)
			FIJX_ALU_COMPL: result = ~operand;
			FIJX_ALU_DEC:   result = operand - `FIJX_ONE_BYTE;
			FIJX_ALU_INC:   result = operand + `FIJX_ONE_BYTE;
			FIJX_ALU_PASS:  result = operand;
		endcase
		zero = (result == `FIJX_ZERO_BYTE);
	end

endmodule : fijx_alu

`default_nettype wire

// [hdl/fijx_exec.sv]
// sequencer for file complement/decrement/increment, skip-on-zero forms and absolute jump
// assumes the file answers a read one cycle after file_rd_en, and the fetch stage
// holds instr stable while instr_valid is high and honours discard and pc loads
`timescale 1ns/100ps
`default_nettype none
`include "fijx_map.svh"

module fijx_exec
	import fijx_pkg::*;
(
	input  wire logic                        mclk,
	input  wire logic                        rst_n,
	input  wire logic                        instr_valid,
	output logic                             instr_ready,
	input  wire logic [`FIJX_INSTR_W-1:0]    instr,
	input  wire logic [`FIJX_LATCH_W-1:0]    pc_high_latch,
	output logic                             file_rd_en,
	output logic      [`FIJX_FADDR_HI:0]     file_rd_addr,
	input  wire logic [`FIJX_DATA_W-1:0]     file_rdata,
	output fijx_wb_type                      wb,
	output fijx_pc_type                      pc,
	output logic                             discard,
	output logic                             done
);

	// sequencer and captured instruction
	fijx_state_type                  state_q, state_d;
	fijx_kind_type                   kind_q, kind_d;
	logic                            dest_q, dest_d;
	logic [`FIJX_FADDR_HI:0]         addr_q, addr_d;
	logic [`FIJX_LIT_HI:0]           lit_q, lit_d;
	// registered outputs
	fijx_wb_type                     wb_q, wb_d;
	fijx_pc_type                     pc_q, pc_d;
	logic                            discard_q, discard_d;
	logic                            done_q, done_d;
	logic                            rd_en_q, rd_en_d;
	// byte unit and jump target
	fijx_alu_type                    alu_op;
	logic [`FIJX_DATA_W-1:0]         alu_res;
	logic                            alu_zero;
	logic [`FIJX_PC_W-1:0]           jump_target;
	logic                            accept;

	// arithmetic on the byte returned by the file
	fijx_alu u_alu
	(
		.op      (alu_op),
		.operand (file_rdata),
		.result  (alu_res),
		.zero    (alu_zero)
	);

	// jump target from the captured literal and the live latch
	fijx_jump u_jump
	(
		.literal (lit_q),
		.latch   (pc_high_latch),
		.target  (jump_target)
	);

	// operation select for the byte unit
	always_comb
	begin
		unique case (kind_q)
			FIJX_K_COMPL:                 alu_op = FIJX_ALU_COMPL;
			FIJX_K_DEC, FIJX_K_DECSKIP:   alu_op = FIJX_ALU_DEC;
			FIJX_K_INC, FIJX_K_INCSKIP:   alu_op = FIJX_ALU_INC;
			default:                      alu_op = FIJX_ALU_PASS;
		endcase
	end

	// handshake: new word only while idle
	assign instr_ready = (state_q == FIJX_ST_IDLE);
	assign accept      = instr_valid && instr_ready;

	// next state, capture and output values
	always_comb
	begin
		state_d   = state_q;
		kind_d    = kind_q;
		dest_d    = dest_q;
		addr_d    = addr_q;
		lit_d     = lit_q;
		wb_d      = '0;
		pc_d      = '0;
		discard_d = 1'b0;
		done_d    = 1'b0;
		rd_en_d   = 1'b0;
		unique case (state_q)
			FIJX_ST_IDLE:
			begin
				if (accept)
				begin
					kind_d = fijx_decode(instr);
					dest_d = instr[`FIJX_DEST_BIT];
					addr_d = instr[`FIJX_FADDR_HI:`FIJX_FADDR_LO];
					lit_d  = instr[`FIJX_LIT_HI:`FIJX_LIT_LO];
					// jumps and unknown words need no operand and go straight to execute
					if (kind_d == FIJX_K_JUMP || kind_d == FIJX_K_OTHER)
						state_d = FIJX_ST_EXEC;
					else
					begin
						state_d = FIJX_ST_READ;
						rd_en_d = 1'b1;
					end
				end
			end
			FIJX_ST_READ:
			begin
				// file answers in the next cycle
				state_d = FIJX_ST_EXEC;
			end
			FIJX_ST_EXEC:
			begin
				done_d  = 1'b1;
				state_d = FIJX_ST_IDLE;
				unique case (kind_q)
					FIJX_K_JUMP:
					begin
						// flags untouched, sequential word thrown away
						pc_d.load   = 1'b1;
						pc_d.target = jump_target;
						discard_d   = 1'b1;
						state_d     = FIJX_ST_NOP;
					end
					FIJX_K_OTHER:
					begin
						done_d = 1'b1;
					end
					default:
					begin
						wb_d.data   = alu_res;
						wb_d.f_addr = addr_q;
						wb_d.w_we   = (dest_q == `FIJX_DEST_ACC);
						wb_d.f_we   = (dest_q == `FIJX_DEST_FILE);
						// increment-and-skip leaves status alone, others write zero
						wb_d.z_we   = (kind_q != FIJX_K_INCSKIP);
						wb_d.z_val  = alu_zero;
						// skip only on a zero result; a non-zero result frees the port at once
						if ((kind_q == FIJX_K_DECSKIP || kind_q == FIJX_K_INCSKIP) && alu_zero)
						begin
							discard_d = 1'b1;
							state_d   = FIJX_ST_NOP;
						end
					end
				endcase
			end
			FIJX_ST_NOP:
			begin
				// second cycle: the discarded word executes as a nop
				state_d = FIJX_ST_IDLE;
			end
		endcase
	end

	// state and output registers
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_q   <= FIJX_ST_IDLE;
			kind_q    <= FIJX_K_OTHER;
			dest_q    <= `FIJX_DEST_ACC;
			addr_q    <= '0;
			lit_q     <= '0;
			wb_q      <= '0;
			pc_q      <= '0;
			discard_q <= 1'b0;
			done_q    <= 1'b0;
			rd_en_q   <= 1'b0;
		end
		else
		begin
			state_q   <= state_d;
			kind_q    <= kind_d;
			dest_q    <= dest_d;
			addr_q    <= addr_d;
			lit_q     <= lit_d;
			wb_q      <= wb_d;
			pc_q      <= pc_d;
			discard_q <= discard_d;
			done_q    <= done_d;
			rd_en_q   <= rd_en_d;
		end
	end

	// outputs straight from flip-flops
	assign file_rd_en   = rd_en_q;
	assign file_rd_addr = addr_q;
	assign wb           = wb_q;
	assign pc           = pc_q;
	assign discard      = discard_q;
	assign done         = done_q;

	// helper: execute cycle of a file-operand instruction
	logic exec_file;
	assign exec_file = (state_q == FIJX_ST_EXEC) && (kind_q != FIJX_K_JUMP) && (kind_q != FIJX_K_OTHER);

	compl_result_a: assert property (
		@(posedge mclk) disable iff (!rst_n)
		(state_q == FIJX_ST_EXEC && kind_q == FIJX_K_COMPL)
		|=> (wb.data == ~$past(file_rdata)) && wb.z_we)
		else $error("complement result or zero write wrong");

	dest_route_a: assert property (
		@(posedge mclk) disable iff (!rst_n)
		exec_file |=> (wb.w_we != wb.f_we) && (wb.f_we == $past(dest_q)) && (wb.f_addr == $past(addr_q)))
		else $error("destination routing wrong");

	dec_result_a: assert property (
		@(posedge mclk) disable iff (!rst_n)
		(state_q == FIJX_ST_EXEC && (kind_q == FIJX_K_DEC || kind_q == FIJX_K_DECSKIP))
		|=> wb.data == $past(file_rdata) - `FIJX_ONE_BYTE)
		else $error("decrement result wrong");

	inc_result_a: assert property (
		@(posedge mclk) disable iff (!rst_n)
		(state_q == FIJX_ST_EXEC && (kind_q == FIJX_K_INC || kind_q == FIJX_K_INCSKIP))
		|=> wb.data == $past(file_rdata) + `FIJX_ONE_BYTE)
		else $error("increment result wrong");

	dec_skip_a: assert property (
		@(posedge mclk) disable iff (!rst_n)
		(state_q == FIJX_ST_EXEC && kind_q == FIJX_K_DECSKIP && file_rdata == `FIJX_ONE_BYTE)
		|=> discard && !instr_ready ##1 instr_ready)
		else $error("decrement skip did not insert one nop cycle");

	inc_skip_a: assert property (
		@(posedge mclk) disable iff (!rst_n)
		(state_q == FIJX_ST_EXEC && kind_q == FIJX_K_INCSKIP)
		|=> !wb.z_we && (discard == (wb.data == `FIJX_ZERO_BYTE)))
		else $error("increment skip flags or skip wrong");

	no_skip_a: assert property (
		@(posedge mclk) disable iff (!rst_n)
		(exec_file && !alu_zero) |=> !discard && instr_ready)
		else $error("non-zero result added a cycle");

	jump_load_a: assert property (
		@(posedge mclk) disable iff (!rst_n)
		(state_q == FIJX_ST_EXEC && kind_q == FIJX_K_JUMP)
		|=> pc.load && !wb.z_we && !wb.w_we && !wb.f_we
			&& pc.target == {$past(pc_high_latch[`FIJX_LATCH_HI:`FIJX_LATCH_LO]), $past(lit_q)})
		else $error("jump target or flags wrong");

	jump_cycles_a: assert property (
		@(posedge mclk) disable iff (!rst_n)
		(accept && fijx_decode(instr) == FIJX_K_JUMP)
		|=> !instr_ready ##1 (discard && !instr_ready) ##1 instr_ready)
		else $error("jump timing wrong");

	zero_flag_a: assert property (
		@(posedge mclk) disable iff (!rst_n)
		wb.z_we |-> wb.z_val == (wb.data == `FIJX_ZERO_BYTE))
		else $error("zero flag does not match result");

	// operand fetch: the addressed byte is requested in the cycle after the word is taken
	operand_read_a: assert property (
		@(posedge mclk) disable iff (!rst_n)
		(accept && fijx_decode(instr) inside {FIJX_K_COMPL, FIJX_K_DEC, FIJX_K_DECSKIP, FIJX_K_INC, FIJX_K_INCSKIP})
		|=> file_rd_en && (file_rd_addr == $past(instr[`FIJX_FADDR_HI:`FIJX_FADDR_LO])))
		else $error("operand read missing or at the wrong address");

	// a second read pulse would hand the byte unit a stale operand
	read_once_a: assert property (
		@(posedge mclk) disable iff (!rst_n)
		file_rd_en |=> !file_rd_en && !instr_ready)
		else $error("file read pulse longer than one cycle");

	// plain file ops finish in three cycles and hand the port back at once
	plain_timing_a: assert property (
		@(posedge mclk) disable iff (!rst_n)
		(accept && fijx_decode(instr) inside {FIJX_K_COMPL, FIJX_K_DEC, FIJX_K_INC})
		|=> !instr_ready [*2] ##1 (done && instr_ready && !discard))
		else $error("plain file op timing wrong");

	// the dropped word is followed by exactly one busy cycle
	nop_cycle_a: assert property (
		@(posedge mclk) disable iff (!rst_n)
		discard |-> !instr_ready ##1 (instr_ready && !discard))
		else $error("nop cycle after discard wrong");

	// a pc load lasting two cycles would make the fetch stage branch twice
	jump_pulse_a: assert property (
		@(posedge mclk) disable iff (!rst_n)
		pc.load |-> discard ##1 (!pc.load && !discard))
		else $error("jump load pulse wrong");

endmodule : fijx_exec

`default_nettype wire

// [hdl/fijx_jump.sv]
// jump target former: 11-bit literal plus high-latch bits into a 15-bit pc
// assumes latch is a stable level from the core's register file
`timescale 1ns/100ps
`default_nettype none
`include "fijx_map.svh"

module fijx_jump
	import fijx_pkg::*;
(
	input  wire logic [`FIJX_LIT_HI:0]      literal,
	input  wire logic [`FIJX_LATCH_W-1:0]   latch,
	output logic      [`FIJX_PC_W-1:0]      target
);

	// upper pc bits come from latch[6:3], the literal fills the lower 11 bits with no overlap
	assign target = {latch[`FIJX_LATCH_HI:`FIJX_LATCH_LO], literal};

endmodule : fijx_jump

`default_nettype wire

// [hdl/fijx_map.svh]
// constant map for the file inc/dec/complement and absolute jump executor
// assumes 14-bit instruction words, 7-bit file addresses and a 15-bit program counter
`ifndef FIJX_MAP_SVH
`define FIJX_MAP_SVH

// instruction word fields
`define FIJX_INSTR_W      14
`define FIJX_OPC_HI       13
`define FIJX_OPC_LO       8
`define FIJX_DEST_BIT     7
`define FIJX_FADDR_HI     6
`define FIJX_FADDR_LO     0
`define FIJX_JOPC_HI      13
`define FIJX_JOPC_LO      11
`define FIJX_LIT_HI       10
`define FIJX_LIT_LO       0

// operation codes
`define FIJX_OPC_COMPL    6'h09
`define FIJX_OPC_DEC      6'h03
`define FIJX_OPC_DECSKIP  6'h0b
`define FIJX_OPC_INC      6'h0a
`define FIJX_OPC_INCSKIP  6'h0f
`define FIJX_JOPC_JUMP    3'h5

// destination bit values
`define FIJX_DEST_ACC     1'h0
`define FIJX_DEST_FILE    1'h1

// high-address latch field that feeds pc[14:11]
`define FIJX_LATCH_W      8
`define FIJX_LATCH_HI     6
`define FIJX_LATCH_LO     3

// data widths and byte constants
`define FIJX_DATA_W       8
`define FIJX_PC_W         15
`define FIJX_ZERO_BYTE    8'h00
`define FIJX_ONE_BYTE     8'h01

`endif

// [hdl/fijx_pkg.sv]
// types shared by the file inc/dec/complement and absolute jump executor
// assumes fijx_map.svh supplies widths and codes
`include "fijx_map.svh"

package fijx_pkg;

	// instruction classes handled here
	typedef enum logic [2:0] {
		FIJX_K_OTHER   = 3'h0,
		FIJX_K_COMPL   = 3'h1,
		FIJX_K_DEC     = 3'h2,
		FIJX_K_DECSKIP = 3'h3,
		FIJX_K_INC     = 3'h4,
		FIJX_K_INCSKIP = 3'h5,
		FIJX_K_JUMP    = 3'h6
	} fijx_kind_type;

	// arithmetic selection for the byte unit
	typedef enum logic [1:0] {
		FIJX_ALU_PASS  = 2'h0,
		FIJX_ALU_COMPL = 2'h1,
		FIJX_ALU_DEC   = 2'h2,
		FIJX_ALU_INC   = 2'h3
	} fijx_alu_type;

	// execution sequencer states
	typedef enum logic [1:0] {
		FIJX_ST_IDLE = 2'h0,
		FIJX_ST_READ = 2'h1,
		FIJX_ST_EXEC = 2'h2,
		FIJX_ST_NOP  = 2'h3
	} fijx_state_type;

	// write-back bundle towards accumulator, file and status
	typedef struct packed {
		logic                        w_we;
		logic                        f_we;
		logic [`FIJX_FADDR_HI:0]     f_addr;
		logic [`FIJX_DATA_W-1:0]     data;
		logic                        z_we;
		logic                        z_val;
	} fijx_wb_type;

	// program counter load bundle
	typedef struct packed {
		logic                        load;
		logic [`FIJX_PC_W-1:0]       target;
	} fijx_pc_type;

	// classify an instruction word
	function automatic fijx_kind_type fijx_decode(input logic [`FIJX_INSTR_W-1:0] instr);
		fijx_kind_type k;
		k = FIJX_K_OTHER;
		if (instr[`FIJX_JOPC_HI:`FIJX_JOPC_LO] == `FIJX_JOPC_JUMP)
			k = FIJX_K_JUMP;
		else
			case (instr[`FIJX_OPC_HI:`FIJX_OPC_LO])
				`FIJX_OPC_COMPL:   k = FIJX_K_COMPL;
				`FIJX_OPC_DEC:     k = FIJX_K_DEC;
				`FIJX_OPC_DECSKIP: k = FIJX_K_DECSKIP;
				`FIJX_OPC_INC:     k = FIJX_K_INC;
				`FIJX_OPC_INCSKIP: k = FIJX_K_INCSKIP;
				default:           k = FIJX_K_OTHER;
			endcase
		return k;
	endfunction : fijx_decode

endpackage : fijx_pkg

// [verif/fijx_file_mdl.sv]
// partner model: data file that answers a read one cycle later and takes file writes
// assumes the executor's read port and write-back bundle on the same clock
`timescale 1ns/100ps
`default_nettype none
`include "fijx_map.svh"

module fijx_file_mdl
	import fijx_pkg::*;
(
	input  wire logic                    mclk,
	input  wire logic                    rst_n,
	input  wire logic                    file_rd_en,
	input  wire logic [`FIJX_FADDR_HI:0] file_rd_addr,
	output logic      [`FIJX_DATA_W-1:0] file_rdata,
	input  wire fijx_wb_type             wb
);
	logic [`FIJX_DATA_W-1:0] mem [0:127];

	// read data holds only in the cycle after a read; elsewhere it flips so stale use shows
	always @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			file_rdata <= 8'h5a;
		else if (file_rd_en)
			file_rdata <= mem[file_rd_addr];
		else
			file_rdata <= ~file_rdata;
		if (rst_n && wb.f_we)
			mem[wb.f_addr] <= wb.data;
	end
endmodule : fijx_file_mdl
`default_nettype wire

// [verif/file_incdec_jump_exec_tb_top.sv]
// self-checking bench for the file op and jump executor
// assumes the partner file model and the design package are compiled first
`timescale 1ns/100ps
`default_nettype none
`include "fijx_map.svh"

module file_incdec_jump_exec_tb_top import fijx_pkg::*;;
	logic        mclk, rst_n, instr_valid, instr_ready, file_rd_en, discard, done, rd1;
	logic [13:0] instr;
	logic [7:0]  pc_high_latch, file_rdata;
	logic [6:0]  file_rd_addr, ra1;
	logic [15:0] lfsr_q, r;
	fijx_wb_type wb, wb_s;
	fijx_pc_type pc, pc_s;
	int          err_count, comparisons, done_c, ready_c, disc_n;
	logic [5:0]  opc_tab [5] = '{6'h09, 6'h03, 6'h0b, 6'h0a, 6'h0f};
	logic [7:0]  val_tab [4] = '{8'h00, 8'h01, 8'hff, 8'h7f};

	fijx_exec dut_u (.mclk(mclk), .rst_n(rst_n), .instr_valid(instr_valid), .instr_ready(instr_ready),
		.instr(instr), .pc_high_latch(pc_high_latch), .file_rd_en(file_rd_en), .file_rd_addr(file_rd_addr),
		.file_rdata(file_rdata), .wb(wb), .pc(pc), .discard(discard), .done(done));
	fijx_file_mdl mdl_u (.mclk(mclk), .rst_n(rst_n), .file_rd_en(file_rd_en), .file_rd_addr(file_rd_addr),
		.file_rdata(file_rdata), .wb(wb));

	// 100 ns clock
	always #50 mclk = ~mclk;

	function automatic logic [15:0] lfsr_next(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr_next

	// expected byte result of each file operation
	function automatic logic [7:0] exp_res(input logic [5:0] opc, input logic [7:0] v);
		case (opc)
			`FIJX_OPC_COMPL:                  return ~v;
			`FIJX_OPC_DEC, `FIJX_OPC_DECSKIP: return v - 8'h01;
			default:                          return v + 8'h01;
		endcase
	endfunction : exp_res

	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		comparisons++;
		if (g !== e)
		begin
			err_count++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic tally_and_finish;
		$display("mismatches %0d comparisons %0d", err_count, comparisons);
		if (err_count == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : tally_and_finish

	// offer one word at a falling edge, then log outputs cycle by cycle until ready returns
	task automatic issue(input logic [13:0] w, input logic pre, input logic [7:0] v);
		instr = w;
		pc_high_latch = lfsr_q[7:0];
		instr_valid = 1'b1;
		lfsr_q = lfsr_next(lfsr_q);
		@(posedge mclk);
		done_c = 0;
		ready_c = 0;
		disc_n = 0;
		for (int c = 1; c < 7 && ready_c == 0; c++)
		begin
			@(negedge mclk);
			if (c == 1)
			begin
				instr_valid = 1'b0;
				rd1 = file_rd_en;
				ra1 = file_rd_addr;
				// operand goes in after the previous write-back edge, so a same-address write cannot clobber it
				if (pre)
					mdl_u.mem[w[6:0]] = v;
			end
			if (done === 1'b1 && done_c == 0)
			begin
				done_c = c;
				wb_s = wb;
				pc_s = pc;
			end
			if (discard === 1'b1)
				disc_n++;
			if (instr_ready === 1'b1)
				ready_c = c;
		end
	endtask : issue

	task automatic file_op(input logic [5:0] opc, input logic d, input logic [6:0] a, input logic [7:0] v);
		logic [7:0] res;
		logic       sk;
		res = exp_res(opc, v);
		sk = (opc == `FIJX_OPC_DECSKIP || opc == `FIJX_OPC_INCSKIP) && res == 8'h00;
		issue({opc, d, a}, 1'b1, v);
		chk("read port", {1'b1, a}, {rd1, ra1});
		chk("done cycle", 16'h3, done_c);
		chk("ready cycle", sk ? 16'h4 : 16'h3, ready_c);
		chk("acc write", {15'h0, ~d}, wb_s.w_we);
		chk("file write", {1'b1, d, a}, {1'b1, wb_s.f_we, wb_s.f_addr});
		chk("result", res, wb_s.data);
		chk("zero write", opc != `FIJX_OPC_INCSKIP, wb_s.z_we);
		if (opc != `FIJX_OPC_INCSKIP)
			chk("zero value", res == 8'h00, wb_s.z_val);
		chk("discard", {15'h0, sk}, disc_n);
		chk("file op pc load", 16'h0, pc_s.load);
	endtask : file_op

	task automatic jump_op(input logic [10:0] k);
		logic [7:0] l;
		l = lfsr_q[7:0];
		issue({`FIJX_JOPC_JUMP, k}, 1'b0, 8'h00);
		chk("jump done", 16'h2, done_c);
		chk("jump ready", 16'h3, ready_c);
		chk("pc target", {1'b1, l[6:3], k}, {pc_s.load, pc_s.target});
		chk("jump discard", 16'h1, disc_n);
		chk("jump flags", 16'h0, {wb_s.z_we, wb_s.w_we, wb_s.f_we});
	endtask : jump_op

	// main sequence: corners per opcode, jump limits, an unknown word, then random mix
	initial
	begin
		mclk = 1'b0;
		rst_n = 1'b0;
		instr_valid = 1'b0;
		instr = 14'h0;
		pc_high_latch = 8'h0;
		err_count = 0;
		comparisons = 0;
		lfsr_q = 16'h32;
		repeat (6) @(negedge mclk);
		rst_n = 1'b1;
		for (int i = 0; i < 5; i++)
			for (int j = 0; j < 4; j++)
				file_op(opc_tab[i], j[0], j[1] ? 7'h7f : 7'h00, val_tab[j]);
		jump_op(11'h000);
		jump_op(11'h7ff);
		issue(14'h3fff, 1'b0, 8'h00);
		chk("other word", 16'h2, done_c);
		chk("other effect", 16'h0, {wb_s.w_we, wb_s.f_we, wb_s.z_we, pc_s.load, disc_n[0]});
		for (int n = 0; n < 300; n++)
		begin
			r = lfsr_q;
			lfsr_q = lfsr_next(lfsr_q);
			if (r[2:0] > 3'h4)
				jump_op(r[13:3]);
			else
				file_op(opc_tab[r[2:0]], r[3], r[10:4], r[15:8]);
		end
		tally_and_finish();
	end

	// watchdog well beyond the expected run length
	initial
	begin
		repeat (6000) @(posedge mclk);
		err_count++;
		tally_and_finish();
	end
endmodule : file_incdec_jump_exec_tb_top
`default_nettype wire
